// ---- include/smsp_pkg.sv ----
// Constants shared by the serial master/slave port
`default_nettype none
package smsp_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_TX_BUFFER = 8'h9a;
    localparam logic [7:0] ADDR_RX_BUFFER = 8'h9b;
    localparam logic [7:0] ADDR_SYS_CONFIG = 8'haf;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'he8;
    localparam logic [7:0] ADDR_CONFIG_TWO = 8'he9;
    localparam logic [7:0] ADDR_STATUS = 8'hea;
    // Reset values
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // System configuration fields
    localparam int POS_PIN_OWNER = 5;
    // Configuration one fields
    localparam int POS_MASTER_MODE = 5;
    localparam int POS_AUTO_SS = 4;
    localparam int POS_IRQ_MODE = 3;
    localparam int POS_OVERWRITE = 2;
    // Configuration two fields
    localparam int POS_CONTINUOUS = 7;
    localparam int POS_CPOL = 3;
    localparam int POS_CPHA = 2;
    localparam int POS_RATE_HI = 1;
    localparam int POS_RATE_LO = 0;
    // Status fields
    localparam int POS_RX_OVERFLOW = 5;
    localparam int POS_RX_NEW = 4;
    localparam int POS_RX_FULL = 3;
    localparam int POS_TX_EMPTY = 1;
    localparam int POS_TX_FULL = 0;
    // Byte framing
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_BASE_CYCLES = 4;
    localparam int GAP_NS = 100;
    localparam int GAP_CYCLES = GAP_NS / CLK_PERIOD_NS;
    localparam logic [7:0] GAP_LAST = 8'(GAP_CYCLES - 1);
    // Master sequencer states
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LEAD = 2'b01,
        M_SHIFT = 2'b11,
        M_GAP = 2'b10
    } smsp_mstate_t;
endpackage : smsp_pkg
`default_nettype wire

// ---- logic/smsp_port.sv ----
// Serial master/slave port with byte buffers and register access
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Data-in pin input as master, output slave
// - Data-out pin output as master, input slave
// - Whole bytes, most significant bit first
// - Clock pin output as master, input slave
// - Master clock rate, polarity, phase from config
// - Launch one edge, sample the opposite edge
// - Slave transfers while select held low
// - Automatic select low during master transfer
// - Select pin may be input for multimaster
// - Continuous mode streams until buffer empty
// - Single byte: write starts, flag, release
// - Continuous: run until both empty, release
// - Idle gap between bytes when not continuous
// - Transmit flag raised when shift loaded
// - Master stops when no new byte written
// - Receive flag set when byte stored
// - Overflow flag; discard or overwrite new byte
// - Owner select bit gives pins to one
// - Reading receive buffer clears receive flag
// - Unread receive stops transfer in mode zero
// - Full flag set on store, read clears
module smsp_port
    import smsp_pkg::*;
(
    // Core clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    // Serial clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Master-out data pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // Master-in data pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // Slave select pin
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe
);
    logic [7:0] sys_config;
    logic [7:0] config_one;
    logic [7:0] config_two;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic tx_full;
    logic tx_empty_flag;
    logic rx_new_data_flag;
    logic rx_full_flag;
    logic rx_overflow_flag;
    logic [7:0] slave_tx;

    // Configuration decode
    logic pin_owner_select;
    logic master_mode;
    logic auto_ss;
    logic transfer_irq_mode;
    logic overflow_overwrite_select;
    logic continuous_mode_bit;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [1:0] rate;
    assign pin_owner_select = sys_config[POS_PIN_OWNER];
    assign master_mode = config_one[POS_MASTER_MODE];
    assign auto_ss = config_one[POS_AUTO_SS];
    assign transfer_irq_mode = config_one[POS_IRQ_MODE];
    assign overflow_overwrite_select = config_one[POS_OVERWRITE];
    assign continuous_mode_bit = config_two[POS_CONTINUOUS];
    assign clock_polarity_bit = config_two[POS_CPOL];
    assign clock_phase_bit = config_two[POS_CPHA];
    assign rate = config_two[POS_RATE_HI:POS_RATE_LO];

    // Register port strobes
    logic wr_tx;
    logic rd_rx;
    logic wr_status;
    assign wr_tx = sfr_we && (sfr_addr == ADDR_TX_BUFFER);
    assign rd_rx = sfr_re && (sfr_addr == ADDR_RX_BUFFER);
    assign wr_status = sfr_we && (sfr_addr == ADDR_STATUS);

    // Pin input and link toggle synchronisers
    logic miso_s1;
    logic miso_s2;
    logic ss_s1;
    logic ss_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic link_tgl;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end
        else
        begin
            miso_s1 <= miso_in;
            miso_s2 <= miso_s1;
            ss_s1 <= ss_n_in;
            ss_s2 <= ss_s1;
            tgl_s1 <= link_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    // Slave link domain, clocked by the incoming serial clock
    logic link_clk;
    logic [2:0] link_bit;
    logic [7:0] link_sh;
    logic [7:0] link_hold;
    logic link_miso;
    assign link_clk = sclk_in ^ (clock_polarity_bit ^ clock_phase_bit);

    always_ff @(posedge link_clk or posedge ss_n_in)
    begin
        if (ss_n_in)
        begin
            link_bit <= 3'h0;
            link_sh <= RESET_BYTE;
        end
        else
        begin
            link_bit <= link_bit + 3'h1;
            link_sh <= {link_sh[6:0], mosi_in};
        end
    end

    // Completed byte handed to the core by a toggle
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_tgl <= 1'b0;
            link_hold <= RESET_BYTE;
        end
        else if (link_bit == LAST_BIT && !ss_n_in)
        begin
            link_tgl <= ~link_tgl;
            link_hold <= {link_sh[6:0], mosi_in};
        end
    end

    always_ff @(negedge link_clk or posedge ss_n_in)
    begin
        if (ss_n_in)
            link_miso <= 1'b0;
        else
            link_miso <= slave_tx[~link_bit];
    end

    logic slave_done;
    assign slave_done = (tgl_s2 ^ tgl_s3) && !master_mode;

    // Master sequencer
    smsp_mstate_t mstate;
    logic [7:0] div_cnt;
    logic [7:0] half_last;
    logic [3:0] edge_cnt;
    logic [7:0] m_tx_sh;
    logic [7:0] m_rx_sh;
    logic tick;
    logic leading;
    logic sample;
    logic byte_end;
    logic can_start;
    logic keep_going;
    logic m_load;
    logic [7:0] m_byte;
    assign half_last = 8'((HALF_BASE_CYCLES << rate) - 1);
    // Bit clock ticks only while framing, so the gap can count freely
    assign tick = (div_cnt == half_last)
        && (mstate == M_LEAD || mstate == M_SHIFT);
    assign leading = !edge_cnt[0];
    assign sample = leading ^ clock_phase_bit;
    assign byte_end = (mstate == M_SHIFT) && tick && (edge_cnt == LAST_EDGE);
    assign can_start = master_mode && pin_owner_select && tx_full;
    assign keep_going = continuous_mode_bit && tx_full
        && (transfer_irq_mode || !rx_new_data_flag);
    assign m_load = ((mstate == M_IDLE) && can_start)
        || (byte_end && keep_going);
    assign m_byte = clock_phase_bit ? {m_rx_sh[6:0], miso_s2} : m_rx_sh;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mstate <= M_IDLE;
            div_cnt <= 8'h00;
            edge_cnt <= 4'h0;
        end
        else
        begin
            div_cnt <= (tick || mstate == M_IDLE) ? 8'h00 : div_cnt + 8'h01;
            case (mstate)
                M_IDLE:
                    if (can_start)
                        mstate <= M_LEAD;
                M_LEAD:
                    if (tick)
                    begin
                        mstate <= M_SHIFT;
                        edge_cnt <= 4'h0;
                    end
                M_SHIFT:
                    if (tick)
                    begin
                        edge_cnt <= edge_cnt + 4'h1;
                        // end when both empty
                        // Every frame ends with a deselect gap
                        if (edge_cnt == LAST_EDGE && !keep_going)
                            mstate <= M_GAP;
                    end
                M_GAP:
                    if (div_cnt == GAP_LAST)
                        mstate <= M_IDLE;
                default:
                    mstate <= M_IDLE;
            endcase
        end
    end

    // Master shift path
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            m_tx_sh <= RESET_BYTE;
            m_rx_sh <= RESET_BYTE;
            mosi_out <= 1'b0;
        end
        else if (m_load)
        begin
            if (clock_phase_bit)
                m_tx_sh <= tx_buf;
            else
            begin
                mosi_out <= tx_buf[7];
                m_tx_sh <= {tx_buf[6:0], 1'b0};
            end
        end
        else if (mstate == M_SHIFT && tick)
        begin
            if (sample)
                m_rx_sh <= {m_rx_sh[6:0], miso_s2};
            else
            begin
                mosi_out <= m_tx_sh[7];
                m_tx_sh <= {m_tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sclk_out <= 1'b0;
        else if (mstate == M_SHIFT && tick)
            sclk_out <= ~sclk_out;
        else if (mstate != M_SHIFT)
            sclk_out <= clock_polarity_bit;
    end

    // Pin direction and select drive
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sclk_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            ss_n_oe <= 1'b0;
            ss_n_out <= 1'b1;
        end
        else
        begin
            sclk_oe <= master_mode && pin_owner_select;
            mosi_oe <= master_mode && pin_owner_select;
            miso_oe <= !master_mode && !ss_s2;
            ss_n_oe <= master_mode && auto_ss;
            ss_n_out <= !((mstate == M_LEAD || mstate == M_SHIFT)
                && auto_ss && master_mode);
        end
    end

    assign miso_out = (link_bit == 3'h0) ? slave_tx[7] : link_miso;

    // Transmit buffer and flags
    logic s_load;
    logic tx_load;
    assign s_load = !master_mode && tx_full && (ss_s2 || slave_done);
    assign tx_load = m_load || s_load;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tx_buf <= RESET_BYTE;
            tx_full <= 1'b0;
            tx_empty_flag <= 1'b0;
            slave_tx <= RESET_BYTE;
        end
        else
        begin
            if (wr_tx)
            begin
                tx_buf <= sfr_wdata;
                tx_full <= 1'b1;
            end
            else if (tx_load)
                tx_full <= 1'b0;
            if (s_load)
                slave_tx <= tx_buf;
            if (tx_load)
                tx_empty_flag <= 1'b1;
            else if (wr_tx)
                tx_empty_flag <= 1'b0;
            else if (wr_status && !sfr_wdata[POS_TX_EMPTY])
                tx_empty_flag <= 1'b0;
        end
    end

    // Receive buffer and flags
    logic rx_done;
    logic [7:0] rx_byte;
    assign rx_done = byte_end || slave_done;
    assign rx_byte = master_mode ? m_byte : link_hold;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rx_buf <= RESET_BYTE;
            rx_new_data_flag <= 1'b0;
            rx_full_flag <= 1'b0;
            rx_overflow_flag <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                if (!rx_new_data_flag || rd_rx || overflow_overwrite_select)
                    rx_buf <= rx_byte;
                rx_new_data_flag <= 1'b1;
                rx_full_flag <= 1'b1;
            end
            else if (rd_rx)
            begin
                rx_new_data_flag <= 1'b0;
                rx_full_flag <= 1'b0;
            end
            if (rx_done && rx_new_data_flag && !rd_rx)
                rx_overflow_flag <= 1'b1;
            else if (wr_status && !sfr_wdata[POS_RX_OVERFLOW])
                rx_overflow_flag <= 1'b0;
        end
    end

    // Configuration writes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sys_config <= RESET_REG;
            config_one <= RESET_REG;
            config_two <= RESET_REG;
        end
        else if (sfr_we)
        begin
            if (sfr_addr == ADDR_SYS_CONFIG)
                sys_config <= sfr_wdata;
            if (sfr_addr == ADDR_CONFIG_ONE)
                config_one <= sfr_wdata;
            if (sfr_addr == ADDR_CONFIG_TWO)
                config_two <= sfr_wdata;
        end
    end

    logic [7:0] status;
    always_comb
    begin
        status = 8'h00;
        status[POS_RX_OVERFLOW] = rx_overflow_flag;
        status[POS_RX_NEW] = rx_new_data_flag;
        status[POS_RX_FULL] = rx_full_flag;
        status[POS_TX_EMPTY] = tx_empty_flag;
        status[POS_TX_FULL] = tx_full;
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sfr_rdata <= 8'h00;
        else if (sfr_re)
        begin
            case (sfr_addr)
                ADDR_RX_BUFFER: sfr_rdata <= rx_buf;
                ADDR_SYS_CONFIG: sfr_rdata <= sys_config;
                ADDR_CONFIG_ONE: sfr_rdata <= config_one;
                ADDR_CONFIG_TWO: sfr_rdata <= config_two;
                ADDR_STATUS: sfr_rdata <= status;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule : smsp_port

`default_nettype wire

// ---- sim/smsp_chk.sv ----
// Assertions on the serial port pins and register reads
`timescale 1ns/1ns
`default_nettype none
module smsp_chk
    import smsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_rdata,
    // Pin drive
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic ss_n_in,
    input wire logic ss_n_out,
    input wire logic ss_n_oe
);
    logic [5:0] edge_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Clock edges within the current frame
    always_ff @(posedge clk)
    begin
        if (!reset_n || ss_n_out)
            edge_cnt <= 6'h0;
        else if (sclk_oe && $changed(sclk_out))
            edge_cnt <= edge_cnt + 6'h1;
    end
    a_reset_idle: assert property ($past(reset_n) == 1'b0 |->
        ss_n_out && !sclk_oe && !mosi_oe && !miso_oe)
        else $error("port not idle after reset");
    a_slave_pins: assert property (miso_oe |-> !mosi_oe && !sclk_oe)
        else $error("slave drives master pins");
    a_master_pins: assert property (mosi_oe |-> sclk_oe)
        else $error("data out driven without clock");
    a_clk_in_frame: assert property (sclk_oe && $past(sclk_oe) && ss_n_oe
        && $changed(sclk_out) |-> !ss_n_out || !$past(ss_n_out))
        else $error("clock toggles outside select");
    a_half_period: assert property (sclk_oe && $past(sclk_oe)
        && $changed(sclk_out) |=> $stable(sclk_out) [*3])
        else $error("clock half period too short");
    a_gap_idle: assert property (ss_n_oe && $rose(ss_n_out)
        |=> ss_n_out [*8])
        else $error("gap between frames too short");
    a_byte_edges: assert property (ss_n_oe && $rose(ss_n_out)
        |-> edge_cnt[3:0] == 4'h0 && edge_cnt != 6'h0)
        else $error("frame not whole bytes");
    a_slave_quiet: assert property (ss_n_in [*5] |-> !miso_oe)
        else $error("slave drives data while deselected");
    a_rx_clear: assert property (sfr_re && sfr_addr == ADDR_RX_BUFFER
        ##2 sfr_re && sfr_addr == ADDR_STATUS |=> !sfr_rdata[POS_RX_NEW])
        else $error("receive flag not cleared by read");
    a_rdata_hold: assert property (!sfr_re |=> $stable(sfr_rdata))
        else $error("read data changed without read");
endmodule : smsp_chk
bind smsp_port smsp_chk chk (.clk(clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out),
    .ss_n_oe(ss_n_oe));
`default_nettype wire

// ---- sim/smsp_far_end.sv ----
// Far-end serial device: slave by default, master on request
`timescale 1ns/1ns
`default_nettype none
module smsp_far_end
(
    // Role and pins
    input wire logic act_master,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic ss_n,
    output logic miso_drv,
    output logic sclk_drv,
    output logic mosi_drv,
    output logic ss_n_drv
);
    logic [7:0] resp = 8'h3c;
    logic [7:0] sh = 8'h00;
    logic [7:0] got [$];
    int cnt = 0;
    initial
    begin
        miso_drv = 1'b0;
        sclk_drv = 1'b0;
        mosi_drv = 1'b0;
        ss_n_drv = 1'b1;
    end
    always @(negedge ss_n)
        if (!act_master)
        begin
            cnt = 0;
            miso_drv = resp[7];
        end
    always @(posedge sclk)
        if (!act_master && !ss_n)
        begin
            sh = {sh[6:0], mosi};
            cnt = (cnt + 1) % 8;
            if (cnt == 0)
            begin
                got.push_back(sh);
                resp = resp + 8'h01;
            end
        end
    always @(negedge sclk)
        if (!act_master && !ss_n)
            miso_drv = resp[3'(7 - cnt)];
    // Released line shows no stale value
    always @(posedge ss_n)
        miso_drv = ~miso_drv;
    // master frame at 6 ns clock
    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        #60 ss_n_drv = 1'b0;
        #61;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_drv = b[i];
            #3 sclk_drv = 1'b1;
            r = {r[6:0], miso};
            #3 sclk_drv = 1'b0;
        end
        got.push_back(r);
        #30 ss_n_drv = 1'b1;
        mosi_drv = ~mosi_drv;
    endtask : send
endmodule : smsp_far_end
`default_nettype wire

// ---- sim/spi_master_slave_port_tb.sv ----
// Self-checking bench for the serial master/slave port
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_port_tb;
    import smsp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_we = 1'b0;
    logic sfr_re = 1'b0;
    logic act_master = 1'b0;
    logic [7:0] sfr_rdata, v;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic ss_n_out, ss_n_oe, miso_drv, sclk_drv, mosi_drv, ss_n_drv;
    int errors = 0;
    int cmp_count = 0;
    int falls = 0;
    wire logic sclk_pin = sclk_oe ? sclk_out : sclk_drv;
    wire logic mosi_pin = mosi_oe ? mosi_out : mosi_drv;
    wire logic miso_pin = miso_oe ? miso_out : miso_drv;
    wire logic ss_pin = ss_n_oe ? ss_n_out : ss_n_drv;
    always #5 clk = ~clk;
    always @(negedge ss_pin) falls++;
    smsp_port dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
        .sfr_rdata(sfr_rdata), .sclk_in(sclk_pin), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(ss_pin), .ss_n_out(ss_n_out),
        .ss_n_oe(ss_n_oe));
    smsp_far_end far (.act_master(act_master), .sclk(sclk_pin),
        .mosi(mosi_pin), .miso(miso_pin), .ss_n(ss_pin),
        .miso_drv(miso_drv), .sclk_drv(sclk_drv), .mosi_drv(mosi_drv),
        .ss_n_drv(ss_n_drv));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'b1;
        @(posedge clk);
        sfr_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_re <= 1'b1;
        @(posedge clk);
        sfr_re <= 1'b0;
        #1 d = sfr_rdata;
    endtask : rd
    task automatic wait_bit(input int pos);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 400 && s[pos] !== 1'b1; i++)
            rd(ADDR_STATUS, s);
    endtask : wait_bit
    task automatic t_reset;
        rd(ADDR_STATUS, v);
        check(v, 8'h00);
        check({4'h0, ss_n_out, sclk_oe, mosi_oe, miso_oe}, 8'h08);
        $display("test reset done");
    endtask : t_reset
    task automatic t_single;
        wr(ADDR_SYS_CONFIG, 8'h20);
        wr(ADDR_CONFIG_ONE, 8'h38);
        wr(ADDR_CONFIG_TWO, 8'h00);
        falls = 0;
        wr(ADDR_TX_BUFFER, 8'ha5);
        wait_bit(POS_RX_NEW);
        check(far.got.pop_front(), 8'ha5);
        rd(ADDR_STATUS, v);
        check(v, 8'h1a);
        rd(ADDR_RX_BUFFER, v);
        check(v, 8'h3c);
        rd(ADDR_STATUS, v);
        check(v, 8'h02);
        check(8'(falls), 8'h01);
        $display("test single done");
    endtask : t_single
    task automatic t_stream(input logic [7:0] c2, input logic [7:0] c1,
        input logic [7:0] f, input logic [7:0] rx);
        wr(ADDR_CONFIG_ONE, c1);
        wr(ADDR_CONFIG_TWO, c2);
        far.resp = 8'h40;
        falls = 0;
        wr(ADDR_TX_BUFFER, 8'h11);
        wait_bit(POS_TX_EMPTY);
        wr(ADDR_TX_BUFFER, 8'h22);
        wait_bit(POS_RX_OVERFLOW);
        check(far.got.pop_front(), 8'h11);
        check(far.got.pop_front(), 8'h22);
        check(8'(falls), f);
        rd(ADDR_STATUS, v);
        check(v, 8'h3a);
        rd(ADDR_RX_BUFFER, v);
        check(v, rx);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, v);
        check(v, 8'h00);
        $display("test stream done");
    endtask : t_stream
    task automatic t_unread;
        wr(ADDR_CONFIG_ONE, 8'h30);
        wr(ADDR_CONFIG_TWO, 8'h80);
        far.resp = 8'h50;
        falls = 0;
        wr(ADDR_TX_BUFFER, 8'h11);
        wait_bit(POS_TX_EMPTY);
        wr(ADDR_TX_BUFFER, 8'h22);
        wait_bit(POS_TX_EMPTY);
        wr(ADDR_TX_BUFFER, 8'h33);
        wait_bit(POS_RX_OVERFLOW);
        repeat (200) @(posedge clk);
        check(8'(falls), 8'h02);
        check(far.got.pop_front(), 8'h11);
        check(far.got.pop_front(), 8'h22);
        check(far.got.pop_front(), 8'h33);
        rd(ADDR_RX_BUFFER, v);
        check(v, 8'h50);
        wr(ADDR_STATUS, 8'h00);
        $display("test unread done");
    endtask : t_unread
    task automatic t_slave;
        wr(ADDR_CONFIG_ONE, 8'h08);
        wr(ADDR_TX_BUFFER, 8'hc3);
        act_master = 1'b1;
        far.send(8'h5a);
        act_master = 1'b0;
        wait_bit(POS_RX_NEW);
        rd(ADDR_RX_BUFFER, v);
        check(v, 8'h5a);
        check(far.got.pop_front(), 8'hc3);
        $display("test slave done");
    endtask : t_slave
    task automatic t_owner;
        wr(ADDR_SYS_CONFIG, 8'h00);
        wr(ADDR_CONFIG_ONE, 8'h38);
        falls = 0;
        wr(ADDR_TX_BUFFER, 8'h77);
        repeat (200) @(posedge clk);
        check({6'h0, sclk_oe, mosi_oe}, 8'h00);
        check(8'(falls), 8'h00);
        $display("test owner done");
    endtask : t_owner
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        // Falling edge also clears the link-side toggle
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_single();
        t_stream(8'h80, 8'h38, 8'h01, 8'h40);
        t_stream(8'h01, 8'h3c, 8'h02, 8'h41);
        t_unread();
        t_slave();
        t_owner();
        report_and_stop();
    end
endmodule : spi_master_slave_port_tb
`default_nettype wire
